// ===== pkg/ulpi_pkg.sv
// package of constants for the ulpi phy pin interface block
// Function
// - deselect tri-states data, direction and next
// - stop ignored while deselected
// - weak pull-downs on data, pull-up on stop
// - fault events reported by receive status commands
// - supply enable bit drives switch output low
// - active-low reset pin clears its two release flops asynchronously, registers on the next clock
// - direction defaults low, bus listens
// - direction high only with bytes for link or while blocking
// - direction high during power-up, reset, suspend
// - stop during a send drops direction on the third clock, ignored while blocking
// - next requests following byte during link send
// - next marks valid received byte
// - next low for register data and status
// - device runs on the core_clk input, bus synchronous
// - one turnaround cycle at each direction change
// - direction high, next low means status byte
package ulpi_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [11:0] ULPI_CTRL_ADDR   = 12'h000;
    localparam logic [11:0] ULPI_STAT_ADDR   = 12'h004;
    localparam logic [11:0] ULPI_RXDATA_ADDR = 12'h008;
    localparam logic [11:0] ULPI_TXDATA_ADDR = 12'h00c;
    // control field positions
    localparam int CTRL_SUPPLY_EN  = 0;
    localparam int CTRL_IND_SEL    = 1;
    localparam int CTRL_IND_INV    = 2;
    localparam int CTRL_IND_BYPASS = 3;
    localparam int CTRL_SUSPEND    = 4;
    localparam int CTRL_FAULT_POL  = 5;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // status field positions
    localparam int STAT_DIR      = 0;
    localparam int STAT_RX_VALID = 1;
    localparam int STAT_TX_FULL  = 2;
    localparam int STAT_FAULT    = 3;
    localparam int STAT_ROLE     = 4;
    localparam int STAT_CMD      = 8;
    // status command supply field values
    localparam logic [1:0] SUPPLY_GOOD  = 2'h3;
    localparam logic [1:0] SUPPLY_FAULT = 2'h0;
    // reset release holding time
    localparam int RST_HOLD_CYC = 4;
    typedef enum logic [2:0] {
        ULPI_ST_BLOCK, ULPI_ST_IDLE, ULPI_ST_TURN_UP, ULPI_ST_SEND,
        ULPI_ST_TURN_DN
    } ulpi_state_t;
endpackage

// ===== design/ulpi_phy.sv
// ulpi phy pin interface: link-facing bus engine with apb control
`timescale 1ns/1ns
module ulpi_phy
    import ulpi_pkg::*;
(
    // clock and reset
    input  wire logic        core_clk,
    input  wire logic        sys_rst,
    input  wire logic        reset_n_pin,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // ulpi bus
    input  wire logic        chip_select_n,
    input  wire logic        stop_in,
    input  wire logic [7:0]  data_in,
    output logic      [7:0]  data_out,
    output logic             data_oe,
    output logic             dir_out,
    output logic             dir_oe,
    output logic             next_out,
    output logic             next_oe,
    // misc pins
    input  wire logic        fault_pin,
    input  wire logic        cable_role_pin,
    output logic             ext_supply_switch_n,
    output logic             ext_supply_switch_oe
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // access phase of one register, taken on the edge where pready is seen
    function automatic logic reg_access(input logic        acc_i,
                                        input logic        rdy_i,
                                        input logic [11:0] addr_i,
                                        input logic [11:0] want_i);
        return acc_i & rdy_i & (addr_i == want_i);
    endfunction

    // status command byte carrying the supply state for one fault level
    function automatic logic [7:0] supply_cmd(input logic fault_i);
        return {4'h0, 2'b00, fault_i ? SUPPLY_FAULT : SUPPLY_GOOD};
    endfunction

    // states in which the device holds the direction whatever it sends
    function automatic logic owns_dir(input ulpi_state_t st_i);
        return (st_i == ULPI_ST_BLOCK) || (st_i == ULPI_ST_TURN_UP);
    endfunction

    // status register word, high fields first
    function automatic logic [31:0] status_word(input logic [7:0] cmd_i,
                                                input logic       role_i,
                                                input logic       flt_i,
                                                input logic       full_i,
                                                input logic       valid_i,
                                                input logic       dir_i);
        return {16'h0000, cmd_i, 3'b000, role_i, flt_i, full_i, valid_i, dir_i};
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] rst_meta;
    logic       ext_rst;
    logic [1:0] cs_s, stp_s, flt_s, role_s;
    logic [7:0] d_s0, d_s1;
    logic       sel, stp, flt, role;

    // active-low pin reset, released through two flops
    always_ff @(posedge core_clk or negedge reset_n_pin) begin
        if (!reset_n_pin) begin
            rst_meta <= 2'b00;
        end else begin
            rst_meta <= {rst_meta[0], 1'b1};
        end
    end
    assign ext_rst = sys_rst | ~rst_meta[1];

    always_ff @(posedge core_clk) begin
        cs_s   <= {cs_s[0], chip_select_n};
        stp_s  <= {stp_s[0], stop_in};
        flt_s  <= {flt_s[0], fault_pin};
        role_s <= {role_s[0], cable_role_pin};
        d_s0   <= data_in;
        d_s1   <= d_s0;
    end
    assign sel  = ~cs_s[1];
    assign stp  = stp_s[1] & sel;
    assign flt  = flt_s[1];
    assign role = role_s[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [31:0] ctrl;
    logic [7:0]  rx_byte;
    logic        rx_valid;
    logic [7:0]  tx_byte;
    logic        tx_full;
    logic        tx_take;
    logic        rx_put;
    logic [7:0]  status_cmd;
    logic        cmd_pending;
    logic [2:0]  rst_cnt;
    ulpi_state_t state;
    logic        wr_en, rd_en;
    logic        send_live, send_cmd, send_byte;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;

    // apb answers in the first access cycle: read data is picked in the
    // setup cycle so that no wait state is ever needed
    logic [31:0] next_prdata;
    logic        next_pslverr;

    always_comb begin
        next_prdata  = 32'h0000_0000;
        next_pslverr = 1'b0;
        if (psel & ~penable) begin
            unique case (paddr)
                ULPI_CTRL_ADDR:   next_prdata = ctrl;
                ULPI_STAT_ADDR:   next_prdata = status_word(status_cmd, role, flt,
                                                            tx_full, rx_valid, dir_out);
                ULPI_RXDATA_ADDR: next_prdata = {24'h000000, rx_byte};
                ULPI_TXDATA_ADDR: next_prdata = {24'h000000, tx_byte};
                default:          next_pslverr = (paddr > ULPI_TXDATA_ADDR);
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            prdata  <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    // control word, changed only on the edge that completes the access
    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            ctrl <= CTRL_RESET;
        end else if (reg_access(wr_en, pready, paddr, ULPI_CTRL_ADDR)) begin
            ctrl <= pwdata;
        end
    end

    // byte taken from link: the link fills rx, software drains it
    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
        end else if (rx_put) begin
            rx_byte  <= d_s1;
            rx_valid <= 1'b1; // set wins over the read clear
        end else if (reg_access(rd_en, pready, paddr, ULPI_RXDATA_ADDR)) begin
            rx_valid <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            tx_byte <= 8'h00;
            tx_full <= 1'b0;
        end else if (reg_access(wr_en, pready, paddr, ULPI_TXDATA_ADDR) && !tx_full) begin
            // a write into a full buffer is dropped, software polls tx_full
            tx_byte <= pwdata[7:0];
            tx_full <= 1'b1;
        end else if (tx_take) begin
            tx_full <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // fault indication and status command
    // ------------------------------------------------------------
    logic fault_seen, fault_prev;
    assign fault_seen = ctrl[CTRL_IND_SEL] & ctrl[CTRL_IND_BYPASS]
                        & (flt ^ ctrl[CTRL_IND_INV]);
    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            fault_prev  <= 1'b0;
            cmd_pending <= 1'b0;
            status_cmd  <= 8'h00;
        end else begin
            fault_prev <= fault_seen;
            if (fault_seen != fault_prev) begin
                cmd_pending <= 1'b1;
                status_cmd  <= supply_cmd(fault_seen);
            end else if (send_cmd) begin
                // a stop during the command cycle leaves it pending for a retry
                cmd_pending <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // bus engine
    // ------------------------------------------------------------
    logic        link_sending;
    ulpi_state_t next_state;
    logic [2:0]  next_rst_cnt;

    // released data lines read low through the pad pull-downs, so an
    // undriven bus never looks like a command from the link
    assign link_sending = (state == ULPI_ST_IDLE) && (d_s1 != 8'h00);

    // the link keeps priority: apart from suspend, which blocks at once, the device turns the bus
    // only while the link is quiet, and only when it holds bytes for the link
    always_comb begin
        next_state   = state;
        next_rst_cnt = rst_cnt;
        unique case (state)
            ULPI_ST_BLOCK: begin
                if (rst_cnt != 3'(RST_HOLD_CYC)) begin
                    next_rst_cnt = rst_cnt + 3'h1;
                end else if (!ctrl[CTRL_SUSPEND]) begin
                    next_state = ULPI_ST_TURN_DN;
                end
            end
            ULPI_ST_IDLE: begin
                if (ctrl[CTRL_SUSPEND]) begin
                    next_state = ULPI_ST_BLOCK;
                end else if ((cmd_pending || tx_full) && !link_sending) begin
                    next_state = ULPI_ST_TURN_UP;
                end
            end
            ULPI_ST_TURN_UP: next_state = ULPI_ST_SEND;
            ULPI_ST_SEND: begin
                if (stp || (!cmd_pending && !tx_full)) begin
                    next_state = ULPI_ST_TURN_DN;
                end
            end
            ULPI_ST_TURN_DN: next_state = ULPI_ST_IDLE;
            // unused codes fall back to blocking the bus
            default:         next_state = ULPI_ST_BLOCK;
        endcase
    end

    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            state   <= ULPI_ST_BLOCK;
            rst_cnt <= 3'h0;
        end else begin
            state   <= next_state;
            rst_cnt <= next_rst_cnt;
        end
    end

    // a send cycle carries a byte only while stop is absent
    assign send_live = (state == ULPI_ST_SEND) && !stp;
    assign send_cmd  = send_live && cmd_pending;
    assign send_byte = send_live && !cmd_pending && tx_full;

    assign tx_take = send_byte;
    assign rx_put  = link_sending && sel;

    // ------------------------------------------------------------
    // bus pins
    // ------------------------------------------------------------
    // direction: high while blocking, turning up, or holding a byte
    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            dir_out <= 1'b1;
        end else begin
            dir_out <= owns_dir(state) || send_cmd || send_byte;
        end
    end

    // next: one pulse per byte taken from the link or per data byte shown;
    // status bytes go out with next low
    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            next_out <= 1'b0;
        end else begin
            next_out <= send_byte || rx_put;
        end
    end

    // status commands outrank buffered bytes; idle data_out is held low with data_oe low
    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            data_out <= 8'h00;
        end else if (send_cmd) begin
            data_out <= status_cmd;
        end else if (send_byte) begin
            data_out <= tx_byte;
        end else begin
            data_out <= 8'h00;
        end
    end

    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            dir_oe  <= 1'b0;
            next_oe <= 1'b0;
            data_oe <= 1'b0;
        end else begin
            dir_oe  <= sel;
            next_oe <= sel;
            // data is driven only in a cycle that also raises direction, so
            // the closing send cycle already leaves the lines to the turnaround
            data_oe <= sel && (send_cmd || send_byte);
        end
    end

    // open-drain supply switch
    always_ff @(posedge core_clk) begin
        if (ext_rst) begin
            ext_supply_switch_n  <= 1'b0;
            ext_supply_switch_oe <= 1'b0;
        end else begin
            ext_supply_switch_n  <= 1'b0;
            ext_supply_switch_oe <= ctrl[CTRL_SUPPLY_EN];
        end
    end
endmodule

// ===== test/ulpi_phy_asserts.sv
// concurrent checks on the ulpi phy pins
`timescale 1ns/1ns
module ulpi_phy_asserts (
    // clock, resets and apb
    input wire logic core_clk, sys_rst, reset_n_pin, psel, penable, pready,
    // ulpi bus and switch
    input wire logic chip_select_n, stop_in, data_oe, dir_out, dir_oe, next_out,
    input wire logic next_oe, ext_supply_switch_n, ext_supply_switch_oe
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst || !reset_n_pin);
    // selection goes through three flops before the pads float
    chk_desel_float: assert property (chip_select_n [*4] |-> !dir_oe && !data_oe && !next_oe)
        else $error("bus outputs driven while deselected");
    chk_rst_dir: assert property (disable iff (1'b0) sys_rst |=> dir_out)
        else $error("direction low during reset");
    chk_pin_reset: assert property (disable iff (sys_rst) $fell(reset_n_pin) |=> dir_out)
        else $error("reset pin did not force direction high");
    chk_switch_low: assert property (ext_supply_switch_oe |-> !ext_supply_switch_n)
        else $error("supply switch enabled but not low");
    chk_data_dir: assert property (data_oe |-> dir_out && dir_oe)
        else $error("data driven with direction low");
    chk_turn_down: assert property ($fell(dir_out) |-> !data_oe)
        else $error("data still driven as direction falls");
    chk_next_pulse: assert property (next_out && !dir_out |=> !next_out)
        else $error("next held for more than one byte");
    chk_stop_abort: assert property ($rose(stop_in) && dir_out && !chip_select_n |-> ##[1:4] !dir_out)
        else $error("stop did not drop direction");
    chk_apb_ready: assert property (psel && !penable |=> pready)
        else $error("apb answer late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready stood two cycles");
    cover property (dir_out && next_out && data_oe);
    cover property (dir_out && data_oe && !next_out);
    cover property (ext_supply_switch_oe);
endmodule

// ===== test/ulpi_link_model.sv
// link-side model: drives idle zeros, command bytes and stop
`timescale 1ns/1ns
module ulpi_link_model (
    // clock and bus direction
    input  wire logic       core_clk,
    input  wire logic       dir_out,
    // bench commands
    input  wire logic       send_req,
    input  wire logic [7:0] send_byte,
    input  wire logic       stop_req,
    // link pins
    output logic      [7:0] link_data,
    output logic            link_oe,
    output logic            stop_in
);
    always_ff @(posedge core_clk) begin
        link_oe   <= !dir_out;
        link_data <= (send_req && !dir_out) ? send_byte : 8'h00;
        stop_in   <= stop_req;
    end
endmodule

// ===== test/ulpi_phy_test.sv
// self-checking bench for the ulpi phy pin block
`timescale 1ns/1ns
module ulpi_phy_test;
    import ulpi_pkg::*;
    logic core_clk, sys_rst, reset_n_pin, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic chip_select_n, stop_in, data_oe, dir_out, dir_oe, next_out, next_oe;
    logic fault_pin, cable_role_pin, ext_supply_switch_n, ext_supply_switch_oe;
    logic [7:0] data_in, data_out, link_data, send_byte;
    logic link_oe, send_req, stop_req;
    int fail_count, total_checks;
    // pull-downs win when nobody drives the data lines
    assign data_in = data_oe ? data_out : (link_oe ? link_data : 8'h00);
    ulpi_phy ulpi_phy_inst (.*);
    ulpi_link_model ulpi_link_model_inst (.core_clk(core_clk), .dir_out(dir_out),
        .send_req(send_req), .send_byte(send_byte), .stop_req(stop_req),
        .link_data(link_data), .link_oe(link_oe), .stop_in(stop_in));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic complete_run;
        $display("checks=%0d mismatches=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    function automatic logic pick(input int k);
        return k == 0 ? dir_out : k == 1 ? next_out : k == 2 ? data_oe : ext_supply_switch_oe;
    endfunction
    task automatic wait_for(input int k, input logic v);
        int n;
        for (n = 0; n < 60 && pick(k) !== v; n++) @(posedge core_clk);
        if (n == 60) begin
            fail_count++;
            complete_run();
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        for (int n = 0; pready !== 1'b1; n++) begin
            if (n == 20) begin fail_count++; complete_run(); end
            @(posedge core_clk);
        end
        rd = prdata; err = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
    task automatic abort_send;
        stop_req <= 1'b1;
        wait_for(0, 1'b0);
        stop_req <= 1'b0;
    endtask
    task automatic t_supply;
        apb(1, ULPI_CTRL_ADDR, 32'h0000_0001);
        wait_for(3, 1'b1);
        chk(ext_supply_switch_n, 1'b0);
        apb(0, ULPI_CTRL_ADDR, 0);
        chk(rd, 32'h0000_0001);
        apb(1, ULPI_CTRL_ADDR, 0);
        wait_for(3, 1'b0);
        apb(1, ULPI_CTRL_ADDR, 32'h0000_0010);
        wait_for(0, 1'b1);
        apb(1, ULPI_CTRL_ADDR, 0);
        wait_for(0, 1'b0);
        apb(0, ULPI_STAT_ADDR, 0);
        chk(rd[STAT_ROLE], 1'b1);
        apb(0, 12'h010, 0);
        chk(err, 1'b1);
    endtask
    task automatic t_rx;
        send_byte <= 8'h5a; send_req <= 1'b1;
        @(posedge core_clk);
        send_req <= 1'b0;
        wait_for(1, 1'b1);
        chk(dir_out, 1'b0);
        apb(0, ULPI_RXDATA_ADDR, 0);
        chk(rd[7:0], 8'h5a);
    endtask
    task automatic t_send;
        apb(1, ULPI_TXDATA_ADDR, 32'h0000_003c);
        wait_for(2, 1'b1);
        chk({dir_out, next_out, data_out}, {2'b11, 8'h3c});
        abort_send;
        apb(1, ULPI_CTRL_ADDR, 32'h0000_000b);
        fault_pin <= 1'b1;
        wait_for(2, 1'b1);
        chk({dir_out, next_out, data_out[1:0]}, {2'b10, SUPPLY_FAULT});
        abort_send;
        apb(1, ULPI_CTRL_ADDR, 32'h0000_000a);
        wait_for(3, 1'b0);
    endtask
    task automatic t_desel;
        chip_select_n <= 1'b1; stop_req <= 1'b1;
        repeat (4) @(posedge core_clk);
        chk({dir_oe, data_oe, next_oe}, 3'b000);
        stop_req <= 1'b0;
        @(posedge core_clk);
        chip_select_n <= 1'b0;
        reset_n_pin <= 1'b0;
        @(posedge core_clk);
        @(posedge core_clk);
        chk(dir_out, 1'b1);
        reset_n_pin <= 1'b1;
        wait_for(0, 1'b0);
    endtask
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        sys_rst = 1; reset_n_pin = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
        chip_select_n = 0; fault_pin = 0; cable_role_pin = 1; send_req = 0; send_byte = 0;
        stop_req = 0; fail_count = 0; total_checks = 0;
        repeat (6) @(posedge core_clk);
        chk(dir_out, 1'b1);
        sys_rst <= 1'b0;
        wait_for(0, 1'b0);
        t_supply;
        t_rx;
        t_send;
        t_desel;
        complete_run();
    end
endmodule
bind ulpi_phy ulpi_phy_asserts ulpi_phy_asserts_inst (.*);
